// ==== pkg/gpio_pkg.sv ====
// shared constants and types for the digital i/o port
package gpio_pkg;

  // =======================================================
  // register access port
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

  // =======================================================
  // register offsets (base registers, aliases add the op offset)
  localparam logic [3:0] SEL_DIR = 4'h0;
  localparam logic [3:0] SEL_PORT = 4'h1;
  localparam logic [3:0] SEL_LAT = 4'h2;
  localparam logic [3:0] SEL_ODC = 4'h3;
  localparam logic [3:0] SEL_ANSEL = 4'h4;
  localparam logic [3:0] SEL_CNEN = 4'h5;
  localparam logic [3:0] SEL_CNSTAT = 4'h6;
  localparam logic [3:0] SEL_PU = 4'h7;
  localparam logic [3:0] SEL_PD = 4'h8;
  localparam int SEL_LSB = 4;
  localparam int OP_LSB = 2;

  // alias operation codes: base, +0x4 clear, +0x8 set, +0xc invert
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CLR = 2'h1,
    OP_SET = 2'h2,
    OP_INV = 2'h3
  } alias_op_t;

  // =======================================================
  // reset values
  localparam logic [DATA_W-1:0] DIR_RESET = 32'hffffffff;
  localparam logic [DATA_W-1:0] ANSEL_RESET = 32'h0000ffff;
  localparam logic [DATA_W-1:0] ZERO_RESET = 32'h00000000;

endpackage

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser bank for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import gpio_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // the first stage feeds only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // pin_sync

// ==== rtl/gpio_port.sv ====
// digital i/o port with change notice and atomic alias writes
// How it works
// - direction bit one means input, zero output; all bits reset to one
// - latch register reads back stored latch, writes update latch
// - pin-level register reads sampled pins; writes go into latch
// - open-drain select makes output drive low only, for any source
// - two-wire bus pins act open-drain without the select bit
// - analog select resets bits 0 to 15 to one (bits 16 and up to zero) so shared pins start analog
// - direction governs only the digital output buffer, analog or not
// - pin-level read returns zero for pins in analog mode
// - enabled input change raises interrupt request, also while sleeping; here only while ref_clk_i keeps toggling
// - only pins with change enable set feed the interrupt request
// - change status shows change since the pin-level bit was last read
// - separate pull-up and pull-down enables, independent of other settings
// - alias writes touch only bits written as one
// - alias reads return undefined values, here zero
// - clear, set, invert aliases sit at base plus 0x4, 0x8, 0xc
`timescale 1ns/1ps
module gpio_port #(
  parameter int WIDTH = 16,
  parameter logic [31:0] TWO_WIRE_MASK = 32'h00000000
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire gpio_pkg::reg_req_t req_i,
  output gpio_pkg::reg_rsp_t rsp_o,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  input wire logic [WIDTH-1:0] remap_sel_i,
  input wire logic [WIDTH-1:0] remap_out_i,
  output logic [WIDTH-1:0] pull_up_o,
  output logic [WIDTH-1:0] pull_down_o,
  output logic [WIDTH-1:0] analog_mode_o,
  output logic change_irq_o
);
  import gpio_pkg::*;

  if (WIDTH < 1 || WIDTH > DATA_W) begin : g_width_check
    $error("gpio_port: WIDTH must be 1 to 32");
  end

  // =======================================================
  // decode
  logic [3:0] sel;
  alias_op_t op;
  logic [WIDTH-1:0] wbits;
  logic [WIDTH-1:0] pin_sampled;
  logic [WIDTH-1:0] pin_level;

  assign sel = req_i.addr[SEL_LSB +: 4];
  assign op = alias_op_t'(req_i.addr[OP_LSB +: 2]);
  assign wbits = req_i.wdata[WIDTH-1:0];

  function automatic logic [WIDTH-1:0] apply_op(
    input logic [WIDTH-1:0] cur,
    input alias_op_t o,
    input logic [WIDTH-1:0] d
  );
    logic [WIDTH-1:0] r;
    r = cur;
    unique case (o)
      OP_WRITE: r = d;
      OP_CLR: r = cur & ~d;
      OP_SET: r = cur | d;
      OP_INV: r = cur ^ d;
    endcase
    return r;
  endfunction

  // =======================================================
  // control registers
  logic [WIDTH-1:0] dir_reg;
  logic [WIDTH-1:0] lat_reg;
  logic [WIDTH-1:0] odc_reg;
  logic [WIDTH-1:0] ansel_reg;
  logic [WIDTH-1:0] cnen_reg;
  logic [WIDTH-1:0] pu_reg;
  logic [WIDTH-1:0] pd_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      dir_reg <= DIR_RESET[WIDTH-1:0];
    end else if (req_i.wr && sel == SEL_DIR) begin
      dir_reg <= apply_op(dir_reg, op, wbits);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      lat_reg <= ZERO_RESET[WIDTH-1:0];
    end else if (req_i.wr && (sel == SEL_LAT || sel == SEL_PORT)) begin
      lat_reg <= apply_op(lat_reg, op, wbits);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      odc_reg <= ZERO_RESET[WIDTH-1:0];
    end else if (req_i.wr && sel == SEL_ODC) begin
      odc_reg <= apply_op(odc_reg, op, wbits);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ansel_reg <= ANSEL_RESET[WIDTH-1:0];
    end else if (req_i.wr && sel == SEL_ANSEL) begin
      ansel_reg <= apply_op(ansel_reg, op, wbits);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnen_reg <= ZERO_RESET[WIDTH-1:0];
    end else if (req_i.wr && sel == SEL_CNEN) begin
      cnen_reg <= apply_op(cnen_reg, op, wbits);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pu_reg <= ZERO_RESET[WIDTH-1:0];
      pd_reg <= ZERO_RESET[WIDTH-1:0];
    end else if (req_i.wr) begin
      if (sel == SEL_PU) begin
        pu_reg <= apply_op(pu_reg, op, wbits);
      end
      if (sel == SEL_PD) begin
        pd_reg <= apply_op(pd_reg, op, wbits);
      end
    end
  end

  // =======================================================
  // pin sampling
  pin_sync #(
    .WIDTH(WIDTH)
  ) pin_sync_i (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .async_i(pin_i),
    .sync_o(pin_sampled)
  );

  // digital input buffer is off for analog pins
  assign pin_level = pin_sampled & ~ansel_reg;

  // =======================================================
  // change notice
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] cnstat_reg;
  logic [WIDTH-1:0] changed;
  logic port_read;

  assign changed = pin_level ^ prev_reg;
  assign port_read = req_i.rd && sel == SEL_PORT && op == OP_WRITE;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      prev_reg <= ZERO_RESET[WIDTH-1:0];
    end else begin
      prev_reg <= pin_level;
    end
  end

  // a change in the read cycle survives the clear; the detector needs
  // the clock, so sleep wake-up relies on ref_clk_i still toggling
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnstat_reg <= ZERO_RESET[WIDTH-1:0];
    end else if (port_read) begin
      cnstat_reg <= changed;
    end else begin
      cnstat_reg <= cnstat_reg | changed;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      change_irq_o <= 1'b0;
    end else begin
      change_irq_o <= |(cnstat_reg & cnen_reg);
    end
  end

  // =======================================================
  // pin drive
  logic [WIDTH-1:0] drive_val;
  logic [WIDTH-1:0] od_eff;

  always_comb begin
    drive_val = (remap_sel_i & remap_out_i) | (~remap_sel_i & lat_reg);
    od_eff = odc_reg | TWO_WIRE_MASK[WIDTH-1:0];
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pin_o <= ZERO_RESET[WIDTH-1:0];
      pin_oe_o <= ZERO_RESET[WIDTH-1:0];
    end else begin
      // open-drain pins only ever drive a low
      pin_o <= drive_val & ~od_eff;
      // direction and an open-drain high gate the buffer, analog mode does not
      pin_oe_o <= ~dir_reg & ~(od_eff & drive_val);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pull_up_o <= ZERO_RESET[WIDTH-1:0];
      pull_down_o <= ZERO_RESET[WIDTH-1:0];
      analog_mode_o <= ANSEL_RESET[WIDTH-1:0];
    end else begin
      pull_up_o <= pu_reg;
      pull_down_o <= pd_reg;
      analog_mode_o <= ansel_reg;
    end
  end

  // =======================================================
  // read path
  logic [WIDTH-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (op == OP_WRITE) begin
      unique case (sel)
        SEL_DIR: rd_mux = dir_reg;
        SEL_PORT: rd_mux = pin_level;
        SEL_LAT: rd_mux = lat_reg;
        SEL_ODC: rd_mux = odc_reg;
        SEL_ANSEL: rd_mux = ansel_reg;
        SEL_CNEN: rd_mux = cnen_reg;
        SEL_CNSTAT: rd_mux = cnstat_reg;
        SEL_PU: rd_mux = pu_reg;
        SEL_PD: rd_mux = pd_reg;
        default: rd_mux = '0;
      endcase
    end
    // alias reads fall through as zero
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.rd;
      rsp_o.rdata <= '0;
      rsp_o.rdata[WIDTH-1:0] <= rd_mux;
    end
  end

endmodule // gpio_port

// ==== sim/pin_board.sv ====
// board model for the port pins
`timescale 1ns/1ps
module pin_board #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic [WIDTH-1:0] drv_i,
  input wire logic [WIDTH-1:0] drv_en_i,
  input wire logic [WIDTH-1:0] pu_i,
  input wire logic [WIDTH-1:0] pd_i,
  input wire logic [WIDTH-1:0] ext_val_i,
  input wire logic [WIDTH-1:0] ext_en_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] float_reg = '0;
  // a bare pin wanders, so nobody can rely on a stale level
  always @(posedge ref_clk_i) float_reg <= ~float_reg;
  always_comb begin
    for (int b = 0; b < WIDTH; b++) begin
      if (drv_en_i[b]) level_o[b] = drv_i[b];
      else if (ext_en_i[b]) level_o[b] = ext_val_i[b];
      else if (pu_i[b]) level_o[b] = 1'b1;
      else if (pd_i[b]) level_o[b] = 1'b0;
      else level_o[b] = float_reg[b];
    end
  end
endmodule // pin_board

// ==== sim/gpio_port_monitor.sv ====
// assertion checker for the digital i/o port
`timescale 1ns/1ps
module gpio_port_monitor #(
  parameter int WIDTH = 16,
  parameter logic [31:0] TWO_WIRE_MASK = 32'h00000000
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire gpio_pkg::reg_req_t req_i,
  input wire gpio_pkg::reg_rsp_t rsp_o,
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pull_up_o,
  input wire logic [WIDTH-1:0] pull_down_o,
  input wire logic [WIDTH-1:0] analog_mode_o
);
  import gpio_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_rd_answered: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read not answered");
  a_valid_needs_rd: assert property (rsp_o.valid |-> $past(req_i.rd))
    else $error("answer without read");
  a_rdata_width: assert property
    (rsp_o.valid |-> (rsp_o.rdata >> WIDTH) == '0)
    else $error("rdata above width");
  a_alias_rd_zero: assert property
    (req_i.rd && req_i.addr[3:2] != 2'h0 |=> rsp_o.rdata == '0)
    else $error("alias read not zero");
  a_unmapped_zero: assert property
    (req_i.rd && req_i.addr[7:4] > 4'h8 |=> rsp_o.rdata == '0)
    else $error("unmapped read not zero");
  a_two_wire_od: assert property
    ((pin_o & TWO_WIRE_MASK[WIDTH-1:0]) == '0)
    else $error("two-wire pin driven high");
  a_analog_reads_0: assert property (req_i.rd && req_i.addr == 8'h10 |=>
    (rsp_o.rdata[WIDTH-1:0] & analog_mode_o & $past(analog_mode_o)) == '0)
    else $error("analog pin read high");
  a_pulls_by_write: assert property
    (!$stable({pull_up_o, pull_down_o}) |-> $past(req_i.wr, 2))
    else $error("pull moved without write");
endmodule // gpio_port_monitor

// ==== sim/gpio_port_tb_top.sv ====
// self-checking bench for the digital i/o port
`timescale 1ns/1ps
module gpio_port_tb_top;
  import gpio_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  reg_req_t req = '0;
  reg_rsp_t rsp;
  logic [15:0] lvl, pin, oe, pu, pd, am, rsel = '0, rout = '0;
  logic [15:0] ext_val = '0, ext_en = '1;
  logic irq;
  int fail_count = 0;
  int tests_run = 0;
  initial forever #20 ref_clk_i = ~ref_clk_i;
  gpio_port #(.WIDTH(16), .TWO_WIRE_MASK(32'h00008000)) gpio_port_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req), .rsp_o(rsp),
    .pin_i(lvl), .pin_o(pin), .pin_oe_o(oe), .remap_sel_i(rsel),
    .remap_out_i(rout), .pull_up_o(pu), .pull_down_o(pd),
    .analog_mode_o(am), .change_irq_o(irq));
  pin_board #(.WIDTH(16)) pin_board_i (.ref_clk_i(ref_clk_i), .drv_i(pin),
    .drv_en_i(oe), .pu_i(pu), .pd_i(pd), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .level_o(lvl));
  // ==============================
  // access tasks
  task automatic chk(input string w, input logic [31:0] s,
    input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
    @(negedge ref_clk_i);
    chk($sformatf("reg %h", a), rsp.valid ? rsp.rdata : 'x, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==============================
  // tests
  initial begin
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h0000ffff);
    chk("oe", {16'h0, oe}, 32'h0);
    rd(8'h40, 32'h0000ffff);
    chk("analog", {16'h0, am}, 32'h0000ffff);
    $display("reset test done");
    wr(8'h44, 32'h0000ffff);
    wr(8'h04, 32'h000080ff);
    wr(8'h20, 32'h000080a5);
    wr(8'h70, 32'h00008000);
    wr(8'h80, 32'h00004000);
    ext_val <= 16'h3c00;
    ext_en <= 16'h7fff;
    repeat (4) @(negedge ref_clk_i);
    chk("oe", {16'h0, oe}, 32'h000000ff);
    chk("pin", {16'h0, pin}, 32'h000000a5);
    chk("pull", {pu, pd}, 32'h80004000);
    rd(8'h20, 32'h000080a5);
    rd(8'h10, 32'h0000bca5);
    // bit 10 becomes an analog input, bits 0 and 1 analog outputs
    wr(8'h48, 32'h00000403);
    repeat (2) @(negedge ref_clk_i);
    chk("oe", {16'h0, oe}, 32'h000000ff);
    rd(8'h10, 32'h0000b8a4);
    $display("io test done");
    wr(8'h10, 32'h00000001);
    rd(8'h20, 32'h00000001);
    wr(8'h28, 32'h00000f00);
    rd(8'h20, 32'h00000f01);
    wr(8'h2c, 32'h00000101);
    rd(8'h20, 32'h00000e00);
    wr(8'h24, 32'h00000e00);
    rd(8'h20, 32'h00000000);
    rd(8'h28, 32'h00000000);
    rd(8'h90, 32'h00000000);
    $display("alias test done");
    wr(8'h20, 32'h00000001);
    wr(8'h30, 32'h00000007);
    rsel <= 16'h0004;
    rout <= 16'h0004;
    repeat (3) @(negedge ref_clk_i);
    chk("oe", {16'h0, oe}, 32'h000080fa);
    chk("pin", {16'h0, pin}, 32'h0);
    $display("open drain test done");
    rd(8'h10, 32'h00003800);
    chk("cn pulls", {30'h0, pu[8], pd[8]}, 32'h0);
    wr(8'h50, 32'h00000100);
    ext_val <= 16'h3e00;
    repeat (6) @(negedge ref_clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    @(posedge ref_clk_i);
    ext_val <= 16'h3f00;
    repeat (8) if (irq !== 1'b1) @(negedge ref_clk_i);
    chk("irq", {31'h0, irq}, 32'h1);
    if (irq !== 1'b1) conclude();
    rd(8'h60, 32'h00000300);
    rd(8'h10, 32'h00003b00);
    repeat (3) @(negedge ref_clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("change test done");
    // short reset in mid-run must restore direction, pull, analog and irq reset values
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h0000ffff);
    chk("pull", {pu, pd}, 32'h0);
    chk("analog", {16'h0, am}, 32'h0000ffff);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("second reset test done");
    conclude();
  end
endmodule // gpio_port_tb_top
bind gpio_port gpio_port_monitor #(.WIDTH(WIDTH),
  .TWO_WIRE_MASK(TWO_WIRE_MASK)) gpio_port_monitor_i (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i), .rsp_o(rsp_o),
  .pin_o(pin_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
  .analog_mode_o(analog_mode_o));
